/* hdl/bpmc_top.sv */
// Contract
// - without IO supply in SHUTDOWN only a sniffer move to VALIDATE
// - validated fault tone in VALIDATE latches inhibit until host clears
// - validate timeout or sleep timer ends VALIDATE; fault tone restarts
// - heartbeat tone does not restart the validate timeout
// - VALIDATE skipped while sniffer disabled, disabled after reset
// - after VALIDATE, validate-seen flag set on next ACTIVE entry
// - fault output low in VALIDATE; without IO supply only to SHUTDOWN
// - IO supply loss in SLEEP or ACTIVE changes no state
// - sniffer enable written in ACTIVE kept in always-on latch
// - inhibit in ACTIVE only from the host inhibit-assert command
// - stack wake, sleep, shutdown and reset tones are ignored
// - pings never cause tones toward the stack
// - all pings ignored while chip select is high
// - after ping shutdown, chain receivers stay off until second wake
// - sleep-to-active ping in ACTIVE only sets interface flags
// - sleep-to-active ping in SLEEP goes ACTIVE with given flags
// - interface select sampled on SHUTDOWN or VALIDATE to ACTIVE, locked after
// - interface select pin becomes SPI-ready output in ACTIVE with SPI selected
// - leaving digital reset sets flag and loads register values
// - digital reset on wake, soft reset, core UV, oscillator fault
// - no unrequested response data, writes get no response
// - validate timeout at least 150 ms from digital supply up
`default_nettype none
module bpmc_top #(
   parameter int WAKE_MIN = bpmc_pkg::WAKE_MIN_CYC,
   parameter int WAKE_MAX = bpmc_pkg::WAKE_MAX_CYC,
   parameter int SHUT_MIN = bpmc_pkg::SHUT_MIN_CYC,
   parameter int S2A_MIN = bpmc_pkg::S2A_MIN_CYC,
   parameter int S2A_MAX = bpmc_pkg::S2A_MAX_CYC,
   parameter int VALID_TIMEOUT = bpmc_pkg::VALID_TIMEOUT_CYC
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic RX,
   input wire logic CS_N,
   input wire logic SCLK,
   input wire logic IO_SUPPLY_OK,
   input wire logic IF_SELECT_I,
   input wire logic SPI_READY,
   input wire logic SNIFFER_WRITE,
   input wire logic SNIFFER_ENABLE_BIT,
   input wire logic SNIFFER_DISABLE_BIT,
   input wire logic INHIBIT_ASSERT_CMD,
   input wire logic INHIBIT_CLEAR,
   input wire logic [1:0] INHIBIT_DISABLE_FIELD,
   input wire logic SOFT_RESET_CMD,
   input wire logic SLEEP_REQ,
   input wire logic CORE_UV,
   input wire logic CHAIN_UV,
   input wire logic FAST_OSC_WDG,
   input wire logic SLOW_OSC_WDG,
   input wire logic SNIFF_DETECT,
   input wire logic FAULT_TONE,
   input wire logic HEARTBEAT_TONE,
   input wire logic SLEEP_TIMER_EXPIRED,
   input wire logic FLAG_CLEAR,
   output logic [1:0] POWER_STATE,
   output logic DIGITAL_RESET,
   output logic REG_LOAD,
   output logic IS_SPI,
   output logic COMM_ENABLE,
   output logic CHAIN_RX_ENABLE,
   output logic SNIFFER_ARMED,
   output logic HOST_INHIBIT_OUT,
   output logic FAULT_OUT_N_O,
   output logic FAULT_OUT_N_OE,
   output logic IF_SELECT_O,
   output logic IF_SELECT_OE,
   output logic DIGITAL_RESET_FLAG,
   output logic VALIDATE_SEEN_FLAG,
   output logic COMM_CLEAR_SEEN,
   output logic STOP_BIT_SEEN,
   output logic COMM_CLEAR_ERROR,
   output logic FORMAT_ERROR
);

   localparam int VW = bpmc_pkg::VALID_CNT_W;
   localparam int RW = bpmc_pkg::DIGITAL_RESET_FLAG_CNT_W;

   typedef struct packed {
      bpmc_pkg::bpmc_mode_type mode;
      bpmc_pkg::bpmc_mode_type after_rst;
      logic in_rst;
      logic [RW-1:0] rst_cnt;
      logic from_off;
      logic load;
      logic spi;
      logic comm;
      logic sniff_on;
      logic val_entered;
      logic shut_by_ping;
      logic chain_rx;
      logic [VW-1:0] val_cnt;
      logic inhibit;
      logic fault_oe;
      logic ifsel_o;
      logic ifsel_oe;
      logic digital_reset_flag_flag;
      logic val_seen;
      logic cc_seen;
      logic stop_seen;
      logic cc_err;
      logic format_error;
   } bpmc_state_type;

   bpmc_state_type s, next_s;

   logic ping_wake;
   logic ping_shut;
   logic ping_s2a;
   logic ping_clocked;

   // ==========================================================
   // ping detection on the host receive line
   // ==========================================================
   // only the host line feeds this; stack tones never reach it
   bpmc_ping_detect #(
      .WAKE_MIN(WAKE_MIN),
      .WAKE_MAX(WAKE_MAX),
      .SHUT_MIN(SHUT_MIN),
      .S2A_MIN(S2A_MIN),
      .S2A_MAX(S2A_MAX)
   ) u_ping (
      .clk(CLK),
      .rst(RST),
      .rx(RX),
      .cs_n(CS_N),
      .sclk(SCLK),
      .ping_wake(ping_wake),
      .ping_shut(ping_shut),
      .ping_s2a(ping_s2a),
      .ping_clocked(ping_clocked)
   );

   logic io_wake;
   logic io_shut;
   logic io_s2a;
   logic core_fault;

   // pings need the IO supply in every mode
   assign io_wake = ping_wake & IO_SUPPLY_OK;
   assign io_shut = ping_shut & IO_SUPPLY_OK;
   assign io_s2a = ping_s2a & IO_SUPPLY_OK;
   assign core_fault = CORE_UV | CHAIN_UV | FAST_OSC_WDG | SLOW_OSC_WDG;

   // ==========================================================
   // mode control
   // ==========================================================
   always_comb begin
      next_s = s;
      next_s.load = 1'b0;

      // hardware set wins over a host clear of the status flags
      if (FLAG_CLEAR) begin
         next_s.digital_reset_flag_flag = 1'b0;
         next_s.val_seen = 1'b0;
         next_s.cc_seen = 1'b0;
         next_s.stop_seen = 1'b0;
         next_s.cc_err = 1'b0;
         next_s.format_error = 1'b0;
      end

      // always-on sniffer latch, untouched by digital reset
      if (s.mode == bpmc_pkg::MODE_ACTIVE && !s.in_rst && SNIFFER_WRITE) begin
         if (SNIFFER_ENABLE_BIT && !SNIFFER_DISABLE_BIT)
            next_s.sniff_on = 1'b1;
         else if (SNIFFER_DISABLE_BIT && !SNIFFER_ENABLE_BIT)
            next_s.sniff_on = 1'b0;
      end

      // host clear of the inhibit latch, assert wins below
      if (INHIBIT_CLEAR && s.mode == bpmc_pkg::MODE_ACTIVE)
         next_s.inhibit = 1'b0;

      if (s.in_rst) begin
         // digital core held; the count gives a fixed reset length
         if (s.rst_cnt != '0) begin
            next_s.rst_cnt = s.rst_cnt - 1'b1;
         end else begin
            next_s.in_rst = 1'b0;
            next_s.mode = s.after_rst;
            next_s.load = 1'b1;
            next_s.digital_reset_flag_flag = 1'b1;
            next_s.cc_seen = 1'b0;
            next_s.stop_seen = 1'b0;
            next_s.cc_err = 1'b0;
            next_s.format_error = 1'b0;
            next_s.val_seen = 1'b0;
            if (s.from_off)
               next_s.spi = IF_SELECT_I;
            next_s.from_off = 1'b0;
            if (s.after_rst == bpmc_pkg::MODE_ACTIVE &&
                s.val_entered) begin
               next_s.val_seen = 1'b1;
               next_s.val_entered = 1'b0;
            end
         end
      end else begin
         case (s.mode)
            bpmc_pkg::MODE_SHUTDOWN: begin
               if (io_wake) begin
                  next_s.in_rst = 1'b1;
                  next_s.rst_cnt = RW'(bpmc_pkg::DIGITAL_RESET_FLAG_HOLD_CYC);
                  next_s.after_rst = bpmc_pkg::MODE_ACTIVE;
                  next_s.from_off = 1'b1;
                  // first wake after ping shutdown keeps rx off
                  next_s.chain_rx = !s.shut_by_ping;
                  next_s.shut_by_ping = 1'b0;
               end else if (SNIFF_DETECT && s.sniff_on) begin
                  // no sniffer, no VALIDATE
                  next_s.mode = bpmc_pkg::MODE_VALIDATE;
                  next_s.val_entered = 1'b1;
                  next_s.val_cnt = '0;
               end
            end
            bpmc_pkg::MODE_VALIDATE: begin
               if (FAULT_TONE) begin
                  next_s.inhibit = 1'b1;
                  next_s.val_cnt = '0;
               end else if (s.val_cnt != VW'(VALID_TIMEOUT)) begin
                  // heartbeat deliberately not a restart
                  next_s.val_cnt = s.val_cnt + 1'b1;
               end
               if (io_wake) begin
                  next_s.in_rst = 1'b1;
                  next_s.rst_cnt = RW'(bpmc_pkg::DIGITAL_RESET_FLAG_HOLD_CYC);
                  next_s.after_rst = bpmc_pkg::MODE_ACTIVE;
                  next_s.from_off = 1'b1;
                  next_s.chain_rx = !s.shut_by_ping;
                  next_s.shut_by_ping = 1'b0;
               end else if (io_shut) begin
                  next_s.mode = bpmc_pkg::MODE_SHUTDOWN;
                  next_s.shut_by_ping = 1'b1;
               end else if (SLEEP_TIMER_EXPIRED ||
                  (!FAULT_TONE && s.val_cnt >= VW'(VALID_TIMEOUT - 1))) begin
                  next_s.mode = bpmc_pkg::MODE_SHUTDOWN;
               end else if (core_fault) begin
                  next_s.in_rst = 1'b1;
                  next_s.rst_cnt = RW'(bpmc_pkg::DIGITAL_RESET_FLAG_HOLD_CYC);
                  next_s.after_rst = bpmc_pkg::MODE_VALIDATE;
               end
            end
            bpmc_pkg::MODE_SLEEP: begin
               if (io_wake || core_fault) begin
                  next_s.in_rst = 1'b1;
                  next_s.rst_cnt = RW'(bpmc_pkg::DIGITAL_RESET_FLAG_HOLD_CYC);
                  next_s.after_rst = io_wake ? bpmc_pkg::MODE_ACTIVE
                                             : bpmc_pkg::MODE_SLEEP;
                  if (io_wake)
                     next_s.chain_rx = 1'b1;
               end else if (io_shut) begin
                  next_s.mode = bpmc_pkg::MODE_SHUTDOWN;
                  next_s.shut_by_ping = 1'b1;
               end else if (io_s2a) begin
                  next_s.mode = bpmc_pkg::MODE_ACTIVE;
                  next_s.cc_seen = !s.spi;
                  next_s.stop_seen = 1'b0;
                  next_s.cc_err = 1'b0;
                  next_s.format_error = 1'b0;
                  if (s.val_entered) begin
                     next_s.val_seen = 1'b1;
                     next_s.val_entered = 1'b0;
                  end
               end
               // supply loss alone moves nothing here
            end
            bpmc_pkg::MODE_ACTIVE: begin
               if (INHIBIT_ASSERT_CMD &&
                   INHIBIT_DISABLE_FIELD != bpmc_pkg::INHIBIT_OFF_CODE)
                  next_s.inhibit = 1'b1;
               if (io_wake || SOFT_RESET_CMD || core_fault) begin
                  next_s.in_rst = 1'b1;
                  next_s.rst_cnt = RW'(bpmc_pkg::DIGITAL_RESET_FLAG_HOLD_CYC);
                  next_s.after_rst = bpmc_pkg::MODE_ACTIVE;
                  if (io_wake)
                     next_s.chain_rx = 1'b1;
               end else if (io_shut) begin
                  next_s.mode = bpmc_pkg::MODE_SHUTDOWN;
                  next_s.shut_by_ping = 1'b1;
               end else if (io_s2a) begin
                  // mode kept; only the interface flags move
                  if (!s.spi) begin
                     next_s.cc_seen = 1'b1;
                     next_s.stop_seen = 1'b1;
                  end else if (ping_clocked) begin
                     next_s.cc_err = 1'b1;
                     next_s.cc_seen = 1'b0;
                  end else begin
                     next_s.format_error = 1'b1;
                     next_s.cc_err = 1'b0;
                     next_s.cc_seen = 1'b0;
                  end
               end else if (SLEEP_REQ) begin
                  next_s.mode = bpmc_pkg::MODE_SLEEP;
               end
            end
            default: begin
               next_s.mode = bpmc_pkg::MODE_SHUTDOWN;
            end
         endcase
      end

      // inhibit held in SHUTDOWN; disable code only gates new asserts
      // fault pin pulled low for the whole VALIDATE stay
      next_s.fault_oe = (next_s.mode == bpmc_pkg::MODE_VALIDATE);

      // data path only in ACTIVE with IO supply; this block never
      // originates responses or tones
      next_s.comm = (next_s.mode == bpmc_pkg::MODE_ACTIVE) &&
                    !next_s.in_rst && IO_SUPPLY_OK;

      // select pin turns into the ready output once ACTIVE with SPI selected
      next_s.ifsel_oe = (next_s.mode == bpmc_pkg::MODE_ACTIVE) &&
                        !next_s.in_rst && next_s.spi;
      next_s.ifsel_o = SPI_READY;
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         s <= '0;
         s.mode <= bpmc_pkg::MODE_SHUTDOWN;
         s.after_rst <= bpmc_pkg::MODE_SHUTDOWN;
         s.sniff_on <= 1'b0;
      end else begin
         s <= next_s;
      end
   end

   // ==========================================================
   // outputs straight from the state register, fault pin level tied low
   // ==========================================================
   assign POWER_STATE = s.mode;
   assign DIGITAL_RESET = s.in_rst;
   assign REG_LOAD = s.load;
   assign IS_SPI = s.spi;
   assign COMM_ENABLE = s.comm;
   assign CHAIN_RX_ENABLE = s.chain_rx;
   assign SNIFFER_ARMED = s.sniff_on;
   assign HOST_INHIBIT_OUT = s.inhibit;
   assign FAULT_OUT_N_O = 1'b0;
   assign FAULT_OUT_N_OE = s.fault_oe;
   assign IF_SELECT_O = s.ifsel_o;
   assign IF_SELECT_OE = s.ifsel_oe;
   assign DIGITAL_RESET_FLAG = s.digital_reset_flag_flag;
   assign VALIDATE_SEEN_FLAG = s.val_seen;
   assign COMM_CLEAR_SEEN = s.cc_seen;
   assign STOP_BIT_SEEN = s.stop_seen;
   assign COMM_CLEAR_ERROR = s.cc_err;
   assign FORMAT_ERROR = s.format_error;

endmodule // bpmc_top
`default_nettype wire

/* hdl/bpmc_pkg.sv */
`default_nettype none
package bpmc_pkg;

   // ==========================================================
   // clock and conversion
   // ==========================================================
   localparam int CLK_PERIOD_NS = 5;

   // least time: round up to whole cycles, never below one
   function automatic int cyc_up(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   // longest time: round down, never below one
   function automatic int cyc_down(input int ns);
      int c;
      c = ns / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   // ==========================================================
   // ping low-time windows
   // ==========================================================
   localparam int WAKE_MIN_NS = 2500000;
   localparam int WAKE_MAX_NS = 3000000;
   localparam int SHUT_MIN_NS = 12500000;
   localparam int S2A_MIN_NS = 250000;
   localparam int S2A_MAX_NS = 300000;
   localparam int WAKE_MIN_CYC = cyc_up(WAKE_MIN_NS);
   localparam int WAKE_MAX_CYC = cyc_down(WAKE_MAX_NS);
   localparam int SHUT_MIN_CYC = cyc_up(SHUT_MIN_NS);
   localparam int S2A_MIN_CYC = cyc_up(S2A_MIN_NS);
   localparam int S2A_MAX_CYC = cyc_down(S2A_MAX_NS);
   localparam int PING_CNT_W = 24;

   // ==========================================================
   // validate timeout and digital reset length
   // ==========================================================
   localparam int VALID_TIMEOUT_NS = 150000000;
   localparam int VALID_TIMEOUT_CYC = cyc_up(VALID_TIMEOUT_NS);
   localparam int VALID_CNT_W = 25;
   localparam int DIGITAL_RESET_FLAG_HOLD_NS = 100;
   localparam int DIGITAL_RESET_FLAG_HOLD_CYC = cyc_up(DIGITAL_RESET_FLAG_HOLD_NS);
   localparam int DIGITAL_RESET_FLAG_CNT_W = 8;

   // ==========================================================
   // encodings
   // ==========================================================
   localparam logic [1:0] INHIBIT_OFF_CODE = 2'h3;

   typedef enum logic [1:0] {
      MODE_SHUTDOWN,
      MODE_VALIDATE,
      MODE_SLEEP,
      MODE_ACTIVE
   } bpmc_mode_type;

endpackage
`default_nettype wire

/* hdl/bpmc_ping_detect.sv */
`default_nettype none
module bpmc_ping_detect #(
   parameter int WAKE_MIN = bpmc_pkg::WAKE_MIN_CYC,
   parameter int WAKE_MAX = bpmc_pkg::WAKE_MAX_CYC,
   parameter int SHUT_MIN = bpmc_pkg::SHUT_MIN_CYC,
   parameter int S2A_MIN = bpmc_pkg::S2A_MIN_CYC,
   parameter int S2A_MAX = bpmc_pkg::S2A_MAX_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic rx,
   input wire logic cs_n,
   input wire logic sclk,
   output logic ping_wake,
   output logic ping_shut,
   output logic ping_s2a,
   output logic ping_clocked
);

   localparam int W = bpmc_pkg::PING_CNT_W;

   typedef struct packed {
      logic [W-1:0] cnt;
      logic low;
      logic sclk_prev;
      logic clocked;
      logic wake;
      logic shut;
      logic s2a;
      logic clk_seen;
   } bpmc_ping_type;

   bpmc_ping_type s, next_s;

   // ==========================================================
   // low-time measurement
   // ==========================================================
   always_comb begin
      next_s = s;
      next_s.wake = 1'b0;
      next_s.shut = 1'b0;
      next_s.s2a = 1'b0;
      next_s.sclk_prev = sclk;
      if (cs_n) begin
         // chip select high aborts any pulse in progress
         next_s.low = 1'b0;
         next_s.cnt = '0;
         next_s.clocked = 1'b0;
      end else if (!rx) begin
         next_s.low = 1'b1;
         // saturate so a long shutdown pulse cannot wrap
         if (s.cnt < W'(SHUT_MIN))
            next_s.cnt = s.cnt + 1'b1;
         if (sclk && !s.sclk_prev)
            next_s.clocked = 1'b1;
      end else if (s.low) begin
         // classify on the rising edge
         next_s.low = 1'b0;
         next_s.cnt = '0;
         next_s.clocked = 1'b0;
         next_s.clk_seen = s.clocked;
         if (s.cnt >= W'(SHUT_MIN))
            next_s.shut = 1'b1;
         else if (s.cnt >= W'(WAKE_MIN) && s.cnt <= W'(WAKE_MAX))
            next_s.wake = 1'b1;
         else if (s.cnt >= W'(S2A_MIN) && s.cnt <= W'(S2A_MAX))
            next_s.s2a = 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         s <= '0;
      else
         s <= next_s;
   end

   assign ping_wake = s.wake;
   assign ping_shut = s.shut;
   assign ping_s2a = s.s2a;
   assign ping_clocked = s.clk_seen;

endmodule // bpmc_ping_detect
`default_nettype wire

/* tb/bpmc_props.sv */
`default_nettype none
module bpmc_props (
   input wire logic CLK,
   input wire logic RST,
   input wire logic RX,
   input wire logic CS_N,
   input wire logic IO_SUPPLY_OK,
   input wire logic SPI_READY,
   input wire logic SNIFF_DETECT,
   input wire logic FAULT_TONE,
   input wire logic SLEEP_TIMER_EXPIRED,
   input wire logic INHIBIT_ASSERT_CMD,
   input wire logic [1:0] INHIBIT_DISABLE_FIELD,
   input wire logic [1:0] POWER_STATE,
   input wire logic DIGITAL_RESET,
   input wire logic REG_LOAD,
   input wire logic IS_SPI,
   input wire logic SNIFFER_ARMED,
   input wire logic HOST_INHIBIT_OUT,
   input wire logic FAULT_OUT_N_O,
   input wire logic FAULT_OUT_N_OE,
   input wire logic IF_SELECT_O,
   input wire logic IF_SELECT_OE,
   input wire logic DIGITAL_RESET_FLAG
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);

   // ==========================================================
   // six low cycles: a sleep-to-active ping
   // ==========================================================
   sequence s_ping6(logic cs);
      RX ##1 (!RX && CS_N == cs) [*6] ##1 RX;
   endsequence

   // ==========================================================
   // properties
   // ==========================================================
   AST_VALIDATE_PIN: assert property (
      POWER_STATE == 2'h1 |-> FAULT_OUT_N_OE && !FAULT_OUT_N_O)
      else $error("fault pin not pulled low in validate");
   AST_SKIP_VALIDATE: assert property (
      POWER_STATE == 2'h0 && !SNIFFER_ARMED |=> POWER_STATE != 2'h1)
      else $error("validate entered while sniffer off");
   AST_SNIFF_ENTRY: assert property (
      POWER_STATE == 2'h0 && SNIFFER_ARMED && SNIFF_DETECT
      |=> POWER_STATE == 2'h1)
      else $error("sniffer hit did not enter validate");
   AST_FAULT_LATCH: assert property (
      POWER_STATE == 2'h1 && FAULT_TONE && !SLEEP_TIMER_EXPIRED
      |=> HOST_INHIBIT_OUT && POWER_STATE == 2'h1)
      else $error("fault tone did not latch inhibit");
   AST_INHIBIT_CAUSE: assert property (
      $rose(HOST_INHIBIT_OUT) && $past(POWER_STATE) == 2'h3
      |-> $past(INHIBIT_ASSERT_CMD) && $past(INHIBIT_DISABLE_FIELD) != 2'h3)
      else $error("inhibit rose in active without command");
   AST_SELECT_OUT: assert property (
      IF_SELECT_OE |-> IS_SPI && POWER_STATE == 2'h3
      && IF_SELECT_O == $past(SPI_READY))
      else $error("select pin driven wrongly");
   AST_S2A_SLEEP: assert property (
      s_ping6(1'b0) ##0 (POWER_STATE == 2'h2 && IO_SUPPLY_OK)
      |-> ##2 POWER_STATE == 2'h3)
      else $error("sleep ping did not reach active");
   AST_CS_IGNORE: assert property (
      s_ping6(1'b1) ##0 POWER_STATE == 2'h2 |-> ##2 POWER_STATE == 2'h2)
      else $error("ping acted on with select high");
   AST_RESET_EXIT: assert property (
      $fell(DIGITAL_RESET) |-> REG_LOAD && DIGITAL_RESET_FLAG ##1 !REG_LOAD)
      else $error("reset exit without load and flag");
endmodule // bpmc_props

bind bpmc_top bpmc_props chk_u (.CLK, .RST, .RX, .CS_N, .IO_SUPPLY_OK,
   .SPI_READY, .SNIFF_DETECT, .FAULT_TONE, .SLEEP_TIMER_EXPIRED,
   .INHIBIT_ASSERT_CMD, .INHIBIT_DISABLE_FIELD, .POWER_STATE, .DIGITAL_RESET,
   .REG_LOAD, .IS_SPI, .SNIFFER_ARMED, .HOST_INHIBIT_OUT, .FAULT_OUT_N_O,
   .FAULT_OUT_N_OE, .IF_SELECT_O, .IF_SELECT_OE, .DIGITAL_RESET_FLAG);
`default_nettype wire

/* tb/bpmc_host_model.sv */
`default_nettype none
module bpmc_host_model #(
   parameter int SHUT_LOW = 100,
   parameter int SHUT_WAIT = 60
) (
   input wire logic clk,
   output logic rx,
   output logic sclk
);
   timeunit 1ns;
   timeprecision 1ps;
   // line idles on its pull-up, clock on its pull-down
   initial begin
      rx = 1'b1;
      sclk = 1'b0;
   end
   // ==========================================================
   // ping: low time alone picks the kind
   // ==========================================================
   task automatic ping(input int n, input bit clocked);
      rx <= 1'b0;
      repeat (n) begin
         if (clocked) sclk <= ~sclk;
         @(posedge clk);
      end
      rx <= 1'b1;
      sclk <= 1'b0;
      @(posedge clk);
      if (n >= SHUT_LOW) repeat (SHUT_WAIT) @(posedge clk);
   endtask
endmodule // bpmc_host_model
`default_nettype wire

/* tb/bridge_power_mode_control_tb.sv */
`default_nettype none
module bridge_power_mode_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int WK = 25, SD = 110, SA = 6, MID = 12, VTO = 50;
   logic CLK = 1'b0, RST = 1'b1, RX, SCLK;
   logic CS_N = 1'b0, IO_SUPPLY_OK = 1'b1, IF_SELECT_I = 1'b0;
   logic SPI_READY = 1'b0, SLEEP_TIMER_EXPIRED = 1'b0;
   logic SNIFFER_ENABLE_BIT = 1'b1, SNIFFER_DISABLE_BIT = 1'b0;
   logic [1:0] INHIBIT_DISABLE_FIELD = 2'h3;
   logic [12:0] pul = 13'h0000;
   logic [1:0] POWER_STATE;
   logic DIGITAL_RESET, REG_LOAD, IS_SPI, COMM_ENABLE, CHAIN_RX_ENABLE;
   logic SNIFFER_ARMED, HOST_INHIBIT_OUT, FAULT_OUT_N_O, FAULT_OUT_N_OE;
   logic IF_SELECT_O, IF_SELECT_OE, DIGITAL_RESET_FLAG, VALIDATE_SEEN_FLAG;
   logic COMM_CLEAR_SEEN, STOP_BIT_SEEN, COMM_CLEAR_ERROR, FORMAT_ERROR;
   int errors = 0, samples_checked = 0;
   // ==========================================================
   // one-cycle control pulses, one bit each
   // ==========================================================
   wire logic SNIFFER_WRITE = pul[0];
   wire logic INHIBIT_ASSERT_CMD = pul[1];
   wire logic INHIBIT_CLEAR = pul[2];
   wire logic SLEEP_REQ = pul[3];
   wire logic SNIFF_DETECT = pul[4];
   wire logic FAULT_TONE = pul[5];
   wire logic HEARTBEAT_TONE = pul[6];
   wire logic FLAG_CLEAR = pul[7];
   wire logic SOFT_RESET_CMD = pul[8];
   wire logic CORE_UV = pul[9];
   wire logic CHAIN_UV = pul[10];
   wire logic FAST_OSC_WDG = pul[11];
   wire logic SLOW_OSC_WDG = pul[12];

   bpmc_host_model host_u (.clk(CLK),
      .rx(RX), .sclk(SCLK));
   bpmc_top #(.WAKE_MIN(20), .WAKE_MAX(30), .SHUT_MIN(100), .S2A_MIN(4),
      .S2A_MAX(8), .VALID_TIMEOUT(VTO)) dut_u (.*);

   always #2.5 CLK = ~CLK;

   // ==========================================================
   // helpers
   // ==========================================================
   task automatic tick(input int n);
      repeat (n) @(posedge CLK);
   endtask
   task automatic go(input logic [12:0] m);
      pul <= m;
      tick(1);
      pul <= 13'h0000;
      tick(2);
   endtask
   task automatic chk(input string nm, input logic [1:0] seen, exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected %s: expected %0h seen %0h", nm, exp, seen);
      end
   endtask
   // bounded wait for reset to end
   task automatic settle();
      int i;
      i = 0;
      tick(3);
      while (DIGITAL_RESET !== 1'b0 && i < 60) begin
         tick(1);
         i++;
      end
      if (i == 60) chk("reset end", 2'h1, 2'h0);
      tick(2);
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // tests need about 700 cycles; allow 20000, near thirty times that
   initial begin
      #100000;
      errors++;
      give_verdict();
   end

   // ==========================================================
   // tests
   // ==========================================================
   initial begin
      tick(6);
      RST <= 1'b0;
      tick(2);
      chk("state", POWER_STATE, 2'h0);
      chk("armed", SNIFFER_ARMED, 1'b0);
      host_u.ping(WK, 1'b0);
      settle();
      chk("state", POWER_STATE, 2'h3);
      chk("digital_reset_flag flag", DIGITAL_RESET_FLAG, 1'b1);
      chk("spi", IS_SPI, 1'b0);
      chk("comm", COMM_ENABLE, 1'b1);
      chk("seen", VALIDATE_SEEN_FLAG, 1'b0);
      host_u.ping(MID, 1'b0);
      settle();
      chk("odd ping", POWER_STATE, 2'h3);
      go(13'h0080);
      host_u.ping(SA, 1'b0);
      settle();
      chk("state", POWER_STATE, 2'h3);
      chk("clr seen", COMM_CLEAR_SEEN, 1'b1);
      chk("stop", STOP_BIT_SEEN, 1'b1);
      chk("no reset", DIGITAL_RESET_FLAG, 1'b0);
      go(13'h0002);
      chk("blocked", HOST_INHIBIT_OUT, 1'b0);
      INHIBIT_DISABLE_FIELD <= 2'h0;
      go(13'h0002);
      chk("inhibit", HOST_INHIBIT_OUT, 1'b1);
      go(13'h0005);
      chk("inhibit clr", HOST_INHIBIT_OUT, 1'b0);
      chk("armed", SNIFFER_ARMED, 1'b1);
      $display("test active done");
      go(13'h0088);
      chk("sleep", POWER_STATE, 2'h2);
      IO_SUPPLY_OK <= 1'b0;
      tick(10);
      chk("io loss", POWER_STATE, 2'h2);
      IO_SUPPLY_OK <= 1'b1;
      CS_N <= 1'b1;
      host_u.ping(SA, 1'b0);
      CS_N <= 1'b0;
      settle();
      chk("cs high", POWER_STATE, 2'h2);
      host_u.ping(SA, 1'b0);
      settle();
      chk("woke", POWER_STATE, 2'h3);
      chk("clr seen", COMM_CLEAR_SEEN, 1'b1);
      chk("stop", STOP_BIT_SEEN, 1'b0);
      $display("test sleep done");
      host_u.ping(SD, 1'b0);
      chk("shut", POWER_STATE, 2'h0);
      chk("armed", SNIFFER_ARMED, 1'b1);
      IO_SUPPLY_OK <= 1'b0;
      go(13'h0010);
      chk("validate", POWER_STATE, 2'h1);
      chk("fault oe", FAULT_OUT_N_OE, 1'b1);
      chk("fault o", FAULT_OUT_N_O, 1'b0);
      go(13'h0020);
      chk("inhibit", HOST_INHIBIT_OUT, 1'b1);
      tick(27);
      go(13'h0040);
      tick(17);
      chk("kept", POWER_STATE, 2'h1);
      tick(22);
      chk("timeout", POWER_STATE, 2'h0);
      SLEEP_TIMER_EXPIRED <= 1'b1;
      go(13'h0010);
      chk("timer", POWER_STATE, 2'h0);
      $display("test validate done");
      IO_SUPPLY_OK <= 1'b1;
      IF_SELECT_I <= 1'b1;
      tick(2);
      host_u.ping(WK, 1'b0);
      settle();
      chk("seen", VALIDATE_SEEN_FLAG, 1'b1);
      chk("spi", IS_SPI, 1'b1);
      chk("chain off", CHAIN_RX_ENABLE, 1'b0);
      host_u.ping(WK, 1'b0);
      settle();
      chk("chain on", CHAIN_RX_ENABLE, 1'b1);
      chk("sel oe", IF_SELECT_OE, 1'b1);
      SPI_READY <= 1'b1;
      tick(3);
      chk("ready", IF_SELECT_O, 1'b1);
      go(13'h0080);
      host_u.ping(SA, 1'b1);
      settle();
      chk("clr err", COMM_CLEAR_ERROR, 1'b1);
      chk("clr seen", COMM_CLEAR_SEEN, 1'b0);
      go(13'h0080);
      host_u.ping(SA, 1'b0);
      settle();
      chk("format_error", FORMAT_ERROR, 1'b1);
      chk("clr err", COMM_CLEAR_ERROR, 1'b0);
      for (int k = 8; k < 13; k++) begin
         go(13'h0080);
         go(13'h0001 << k);
         settle();
         chk("src flag", DIGITAL_RESET_FLAG, 1'b1);
         chk("src state", POWER_STATE, 2'h3);
      end
      SNIFFER_ENABLE_BIT <= 1'b0;
      SNIFFER_DISABLE_BIT <= 1'b1;
      go(13'h0001);
      chk("disarm", SNIFFER_ARMED, 1'b0);
      $display("test spi and resets done");
      give_verdict();
   end
endmodule // bridge_power_mode_control_tb
`default_nettype wire
